// file: rtl/adc_phase_sequencer.sv
// three-phase integrating converter sequencer
`timescale 1ns/1ns
module adc_phase_sequencer
   import adc_seq_pkg::*;
#(
   parameter logic [CNT_W-1:0] ZERO_CYCLES  = ZERO_CYCLES_DEF,
   parameter logic [CNT_W-1:0] INTEG_CYCLES = INTEG_CYCLES_DEF,
   parameter logic [CNT_W-1:0] DEINT_MAX    = DEINT_MAX_DEF
)
(
   // clock and reset
   input  wire logic                    I_SYS_CLK,
   input  wire logic                    I_RST,
   // comparator and control pins
   input  wire logic                    I_COMPARATOR_POLARITY_OUT,
   input  wire logic                    I_EXT_TRIGGER,
   input  wire logic                    I_HOLD_N,
   input  wire logic                    I_EXT_TRIG_MODE,
   input  wire logic                    I_OHMS_MODE,
   // switch drives and phase levels
   output adc_seq_pkg::switch_s         O_SWITCH,
   output adc_seq_pkg::phase_ctl_s      O_PHASE_CTL,
   output logic                         O_OHMS_REF_SEL,
   // status and result
   output logic                         O_READY,
   output logic                         O_INTEG_DONE,
   output logic                         O_RESULT_POSITIVE,
   output logic [adc_seq_pkg::CNT_W-1:0] O_RESULT
);
   import adc_seq_pkg::*;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic pol_s;
   logic trig_s;
   logic hold_n_s;
   logic ext_mode_s;
   logic ohms_s;

   adc_sync2 u_sync_pol
   (
      .i_clk (I_SYS_CLK),
      .i_rst (I_RST),
      .i_d   (I_COMPARATOR_POLARITY_OUT),
      .o_q   (pol_s)
   );

   adc_sync2 u_sync_trig
   (
      .i_clk (I_SYS_CLK),
      .i_rst (I_RST),
      .i_d   (I_EXT_TRIGGER),
      .o_q   (trig_s)
   );

   adc_sync2 u_sync_hold
   (
      .i_clk (I_SYS_CLK),
      .i_rst (I_RST),
      .i_d   (I_HOLD_N),
      .o_q   (hold_n_s)
   );

   adc_sync2 u_sync_ext
   (
      .i_clk (I_SYS_CLK),
      .i_rst (I_RST),
      .i_d   (I_EXT_TRIG_MODE),
      .o_q   (ext_mode_s)
   );

   adc_sync2 u_sync_ohms
   (
      .i_clk (I_SYS_CLK),
      .i_rst (I_RST),
      .i_d   (I_OHMS_MODE),
      .o_q   (ohms_s)
   );

   // ------------------------------------------------------------
   // trigger detection
   // ------------------------------------------------------------
   logic trig_d_reg;
   logic trig_rise;
   logic start_req;

   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
         trig_d_reg <= 1'b0;
      else
         trig_d_reg <= trig_s;
   end

   assign trig_rise = trig_s & ~trig_d_reg;
   // external mode waits for a pulse, internal mode free-runs unless held
   assign start_req = ext_mode_s ? trig_rise : hold_n_s;

   // ------------------------------------------------------------
   // phase machine
   // ------------------------------------------------------------
   phase_e            phase_reg;
   phase_e            phase_next;
   logic [CNT_W-1:0]  count;
   logic              restart;
   logic              pol_ref_reg;
   logic              neg_sel_reg;
   logic              pos_sel_reg;
   logic              zero_done;
   logic              integ_done;
   logic              deint_done;

   adc_timebase u_timebase
   (
      .i_clk     (I_SYS_CLK),
      .i_rst     (I_RST),
      .i_restart (restart),
      .o_count   (count)
   );

   assign zero_done  = (phase_reg == PH_ZERO)  && (count == ZERO_CYCLES - 24'h000001);
   assign integ_done = (phase_reg == PH_INTEG) && (count == INTEG_CYCLES - 24'h000001);
   // polarity flip ends de-integration; a ceiling guards a dead comparator
   assign deint_done = (phase_reg == PH_DEINT)
                       && ((pol_s != pol_ref_reg) || (count == DEINT_MAX));

   always_comb
   begin
      phase_next = phase_reg;
      unique case (phase_reg)
         PH_IDLE:  if (start_req) phase_next = PH_ZERO;
         PH_ZERO:  if (zero_done) phase_next = PH_INTEG;
         PH_INTEG: if (integ_done) phase_next = PH_DEINT;
         PH_DEINT:
         begin
            if (deint_done)
               phase_next = start_req ? PH_ZERO : PH_IDLE;
         end
      endcase
   end

   assign restart = (phase_next != phase_reg) || (phase_reg == PH_IDLE);

   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
         phase_reg <= PH_IDLE;
      else
         phase_reg <= phase_next;
   end

   // ------------------------------------------------------------
   // polarity sample at end of integration
   // ------------------------------------------------------------
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         pol_ref_reg <= 1'b0;
         neg_sel_reg <= 1'b0;
         pos_sel_reg <= 1'b0;
      end
      else if (integ_done)
      begin
         // pol high means positive input: positive-input select
         pol_ref_reg <= pol_s;
         pos_sel_reg <= pol_s;
         neg_sel_reg <= ~pol_s;
      end
      else if (deint_done)
      begin
         neg_sel_reg <= 1'b0;
         pos_sel_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // switch and phase level decode
   // ------------------------------------------------------------
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_SWITCH    <= SW_RST;
         O_PHASE_CTL <= CTL_RST;
      end
      else
      begin
         O_SWITCH.input_sw    <= (phase_next == PH_INTEG);
         O_SWITCH.short_sw    <= (phase_next == PH_ZERO);
         O_SWITCH.servo_sw    <= (phase_next == PH_ZERO);
         // negative input uses positive reference: ground positive terminal's mate
         O_SWITCH.pos_ref_sw  <= (phase_next == PH_DEINT) && ~phase_ctl_pos();
         O_SWITCH.neg_ref_sw  <= (phase_next == PH_DEINT) && phase_ctl_pos();
         O_SWITCH.fast_chg_sw <= 1'b0;
         O_PHASE_CTL.zero_phase_ctl      <= (phase_next == PH_ZERO);
         O_PHASE_CTL.integrate_phase_ctl <= (phase_next == PH_INTEG);
         O_PHASE_CTL.neg_input_ref_sel   <= (phase_next == PH_DEINT) && ~phase_ctl_pos();
         O_PHASE_CTL.pos_input_ref_sel   <= (phase_next == PH_DEINT) && phase_ctl_pos();
      end
   end

   // polarity in force for the coming de-integration
   function automatic logic phase_ctl_pos();
      phase_ctl_pos = integ_done ? pol_s : pol_ref_reg;
   endfunction

   // resistance mode: de-integrate from the known resistor
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
         O_OHMS_REF_SEL <= 1'b0;
      else
         O_OHMS_REF_SEL <= ohms_s && (phase_next == PH_DEINT);
   end

   // ------------------------------------------------------------
   // result and status
   // ------------------------------------------------------------
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_RESULT          <= CNT_RST;
         O_RESULT_POSITIVE <= 1'b0;
      end
      else if (deint_done)
      begin
         O_RESULT          <= count;
         O_RESULT_POSITIVE <= pol_ref_reg;
      end
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_READY      <= 1'b1;
         O_INTEG_DONE <= 1'b1;
      end
      else
      begin
         O_READY      <= (phase_next == PH_IDLE) || deint_done;
         O_INTEG_DONE <= ~((phase_next == PH_ZERO) || (phase_next == PH_INTEG));
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_one_ref_only: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      !(O_PHASE_CTL.neg_input_ref_sel && O_PHASE_CTL.pos_input_ref_sel))
      else $error("both reference selects active");

   a_zero_switches: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      O_PHASE_CTL.zero_phase_ctl |-> (O_SWITCH.short_sw && O_SWITCH.servo_sw
         && !O_SWITCH.input_sw && !O_SWITCH.pos_ref_sw && !O_SWITCH.neg_ref_sw
         && !O_SWITCH.fast_chg_sw))
      else $error("zero phase switch pattern wrong");

   a_integ_switches: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      O_PHASE_CTL.integrate_phase_ctl |-> (O_SWITCH.input_sw && !O_SWITCH.short_sw
         && !O_SWITCH.servo_sw && !O_SWITCH.pos_ref_sw && !O_SWITCH.neg_ref_sw))
      else $error("integration switch pattern wrong");

   a_zero_to_integ: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      $fell(O_PHASE_CTL.zero_phase_ctl) |-> $rose(O_PHASE_CTL.integrate_phase_ctl))
      else $error("zero level fell without integration");

   a_integ_to_ref: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      $fell(O_PHASE_CTL.integrate_phase_ctl) |->
         (O_PHASE_CTL.neg_input_ref_sel || O_PHASE_CTL.pos_input_ref_sel))
      else $error("integration ended without reference");

   a_no_skip_zero: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      $rose(O_PHASE_CTL.integrate_phase_ctl) |-> $past(O_PHASE_CTL.zero_phase_ctl))
      else $error("integration without zero phase");

   a_result_load: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      deint_done |=> (O_RESULT == $past(count)))
      else $error("result not loaded");

   a_ready_busy: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      ((O_PHASE_CTL.zero_phase_ctl || O_PHASE_CTL.integrate_phase_ctl) && !$past(deint_done))
         |-> !O_READY)
      else $error("ready high while converting");

   a_ready_rise: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      $fell(O_PHASE_CTL.neg_input_ref_sel || O_PHASE_CTL.pos_input_ref_sel) |-> $rose(O_READY))
      else $error("ready did not rise at end of conversion");

   a_integ_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      $fell(O_PHASE_CTL.integrate_phase_ctl) |-> $rose(O_INTEG_DONE))
      else $error("integration status did not rise");

   a_hold_idle: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (phase_reg == PH_IDLE && !ext_mode_s && !hold_n_s) |=> phase_reg == PH_IDLE)
      else $error("conversion started under hold");

   a_deint_end: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (phase_reg == PH_DEINT && pol_s != pol_ref_reg) |=> phase_reg != PH_DEINT)
      else $error("de-integration did not end on flip");
endmodule

// file: include/adc_seq_pkg.sv
// package: constants and carriers for the integrating converter sequencer
package adc_seq_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 25000000;
   localparam int unsigned CONV_PER_SEC  = 12;
   localparam int unsigned CONV_CYCLES   = CLK_HZ / CONV_PER_SEC;
   localparam int unsigned CNT_W         = 24;
   localparam logic [CNT_W-1:0] ZERO_CYCLES_DEF  = 24'h030d40;
   localparam logic [CNT_W-1:0] INTEG_CYCLES_DEF = 24'h030d40;
   localparam logic [CNT_W-1:0] DEINT_MAX_DEF    = 24'h0c3500;
   localparam real  TRIG_MIN_US  = 1.0;
   localparam real  TRIG_MAX_MS  = 16.0;
   localparam int unsigned TRIG_MIN_CYCLES = 25;
   localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef enum logic [1:0] {PH_IDLE, PH_ZERO, PH_INTEG, PH_DEINT} phase_e;

   typedef struct packed {
      logic input_sw;
      logic short_sw;
      logic servo_sw;
      logic pos_ref_sw;
      logic neg_ref_sw;
      logic fast_chg_sw;
   } switch_s;

   typedef struct packed {
      logic zero_phase_ctl;
      logic integrate_phase_ctl;
      logic neg_input_ref_sel;
      logic pos_input_ref_sel;
   } phase_ctl_s;

   localparam switch_s SW_RST = 6'h00;
   localparam phase_ctl_s CTL_RST = 4'h0;

endpackage

// file: rtl/adc_sync2.sv
// two-stage synchroniser for an asynchronous level
`timescale 1ns/1ns
module adc_sync2
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // data
   input  wire logic i_d,
   output logic      o_q
);
   logic meta_reg;
   logic q_reg;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         meta_reg <= 1'b0;
         q_reg    <= 1'b0;
      end
      else
      begin
         meta_reg <= i_d;
         q_reg    <= meta_reg;
      end
   end

   assign o_q = q_reg;
endmodule

// file: rtl/adc_timebase.sv
// time-base counter shared by all three phases
`timescale 1ns/1ns
module adc_timebase
   import adc_seq_pkg::*;
(
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // control
   input  wire logic             i_restart,
   // count
   output logic [CNT_W-1:0]      o_count
);
   logic [CNT_W-1:0] count_reg;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         count_reg <= CNT_RST;
      else if (i_restart)
         count_reg <= CNT_RST;
      else if (count_reg != {CNT_W{1'b1}})
         count_reg <= count_reg + 24'h000001;
   end

   assign o_count = count_reg;
endmodule

// file: verification/adc_analog_model.sv
// far side model: integrator, reference capacitor network, comparator
`timescale 1ns/1ns
module adc_analog_model
   import adc_seq_pkg::*;
#(
   parameter int REF_STEP = 4
)
(
   // clock
   input  wire logic                  i_clk,
   // switch drives and analog input
   input  wire adc_seq_pkg::switch_s  i_switch,
   input  wire logic signed [15:0]    i_vin,
   // comparator
   output logic                       o_polarity
);
   int acc = 0;
   initial o_polarity = 1'b0;
   // one stored magnitude serves both reference polarities
   always @(posedge i_clk)
   begin
      if (i_switch.short_sw)
         acc = 0;
      if (i_switch.input_sw)
         acc = acc + i_vin;
      if (i_switch.pos_ref_sw)
         acc = acc + REF_STEP;
      if (i_switch.neg_ref_sw)
         acc = acc - REF_STEP;
      o_polarity <= #1 (acc > 0);
   end
endmodule

// file: verification/tb_integrating_adc_phase_sequencer.sv
// self-checking bench for the converter phase sequencer
`timescale 1ns/1ns
module tb_integrating_adc_phase_sequencer;
   import adc_seq_pkg::*;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   localparam int ZC  = 20;
   localparam int IC  = 20;
   localparam int DM  = 100;
   localparam int REF = 4;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic               pol;
   logic               trig = 1'b0;
   logic               hold_n = 1'b1;
   logic               ext_mode = 1'b1;
   logic               ohms = 1'b0;
   logic signed [15:0] vin = 16'sh0000;
   switch_s            sw;
   phase_ctl_s         ctl;
   logic               ohms_sel;
   logic               ready;
   logic               idone;
   logic               rpos;
   logic [CNT_W-1:0]   result;
   logic [CNT_W-1:0]   held;
   int                 miscompares = 0;
   int                 checks_done = 0;

   always #20 clk = ~clk;

   adc_phase_sequencer #(
      .ZERO_CYCLES  (24'h000014),
      .INTEG_CYCLES (24'h000014),
      .DEINT_MAX    (24'h000064)
   ) i_dut (
      .I_SYS_CLK                 (clk),
      .I_RST                     (rst),
      .I_COMPARATOR_POLARITY_OUT (pol),
      .I_EXT_TRIGGER             (trig),
      .I_HOLD_N                  (hold_n),
      .I_EXT_TRIG_MODE           (ext_mode),
      .I_OHMS_MODE               (ohms),
      .O_SWITCH                  (sw),
      .O_PHASE_CTL               (ctl),
      .O_OHMS_REF_SEL            (ohms_sel),
      .O_READY                   (ready),
      .O_INTEG_DONE              (idone),
      .O_RESULT_POSITIVE         (rpos),
      .O_RESULT                  (result)
   );

   adc_analog_model #(.REF_STEP(REF)) i_far (
      .i_clk      (clk),
      .i_switch   (sw),
      .i_vin      (vin),
      .o_polarity (pol)
   );

   // ------------------------------------------------------------
   // compare and report
   // ------------------------------------------------------------
   task automatic fail(input string msg);
      miscompares++;
      $display("[FAIL] %0t ns: %s", $time, msg);
   endtask

   task automatic chk1(input logic got, input logic exp, input string msg);
      checks_done++;
      if (got !== exp) fail(msg);
   endtask

   task automatic chk6(input switch_s got, input switch_s exp, input string msg);
      checks_done++;
      if (got !== exp) fail(msg);
   endtask

   task automatic chk4(input phase_ctl_s got, input phase_ctl_s exp, input string msg);
      checks_done++;
      if (got !== exp) fail(msg);
   endtask

   task automatic chkn(input logic [CNT_W-1:0] got, input int lo, input int hi, input string msg);
      checks_done++;
      if ($isunknown(got) || got < lo || got > hi) fail(msg);
   endtask

   task automatic summarize;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ------------------------------------------------------------
   // stimulus tasks
   // ------------------------------------------------------------
   task automatic pulse;
      trig = 1'b1;
      repeat (TRIG_MIN_CYCLES) @(negedge clk);
      trig = 1'b0;
   endtask

   task automatic idle_chk(input int cycles);
      held = result;
      repeat (cycles)
      begin
         @(negedge clk);
         chk4(ctl, 4'h0, "conversion started");
         chk1(ready, 1'b1, "ready dropped");
         chkn(result, int'(held), int'(held), "result changed");
      end
   endtask

   task automatic convert(input int v, input int wait_max, input logic drop_hold);
      int n;
      int lo;
      logic chained;
      n = 0;
      chained = (ctl.zero_phase_ctl === 1'b1);
      while (ctl.zero_phase_ctl !== 1'b1 && n < wait_max)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= wait_max)
      begin
         fail("no zero phase");
         summarize();
      end
      chk1(ready, chained, "ready at zero start");
      n = 0;
      while (ctl.zero_phase_ctl === 1'b1 && n < 200)
      begin
         chk6(sw, 6'h18, "zero switches");
         if (n > 0) chk1(ready, 1'b0, "ready in zero");
         chk1(idone, 1'b0, "status in zero");
         @(negedge clk);
         n++;
      end
      if (drop_hold) hold_n = 1'b0;
      chkn(n, ZC, ZC, "zero length");
      chk4(ctl, 4'h4, "zero to integrate");
      n = 0;
      while (ctl.integrate_phase_ctl === 1'b1 && n < 200)
      begin
         chk6(sw, 6'h20, "integrate switches");
         chk1(ready, 1'b0, "ready in integrate");
         @(negedge clk);
         n++;
      end
      chkn(n, IC, IC, "integrate length");
      chk1(idone, 1'b1, "status after integrate");
      chk4(ctl, v > 0 ? 4'h1 : 4'h2, "reference select");
      chk6(sw, v > 0 ? 6'h02 : 6'h04, "reference switch");
      chk1(ohms_sel, ohms, "ohms reference");
      n = 0;
      while (ctl[1:0] !== 2'b00 && n < 300)
      begin
         chk1(ready, 1'b0, "ready in discharge");
         @(negedge clk);
         n++;
      end
      if (n >= 300)
      begin
         fail("discharge hung");
         summarize();
      end
      lo = (IC * (v < 0 ? -v : v) + REF - 1) / REF;
      if (lo > DM) lo = DM;
      chkn(n, lo, lo + 4, "discharge length");
      chk1(ready, 1'b1, "end of conversion");
      chk1(rpos, v > 0, "result sign");
      chkn(result, n - 1, n + 1, "result count");
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      chk1((ZERO_CYCLES_DEF + INTEG_CYCLES_DEF + DEINT_MAX_DEF) < CONV_CYCLES, 1'b1, "rate");
      repeat (4) @(negedge clk);
      chk6(sw, 6'h00, "reset switches");
      chk4(ctl, 4'h0, "reset phase");
      chk1(ready, 1'b1, "reset ready");
      chk1(idone, 1'b1, "reset status");
      chkn(result, 0, 0, "reset result");
      rst = 1'b0;
      idle_chk(10);
      vin = 16'sd3;
      fork
         pulse();
         convert(3, 20, 1'b0);
      join
      idle_chk(60);
      vin = -16'sd3;
      ohms = 1'b1;
      fork
         pulse();
         convert(-3, 20, 1'b0);
      join
      vin = 16'sd25;
      ohms = 1'b0;
      fork
         pulse();
         convert(25, 20, 1'b0);
      join
      hold_n = 1'b0;
      repeat (4) @(negedge clk);
      ext_mode = 1'b0;
      idle_chk(60);
      vin = 16'sd1;
      hold_n = 1'b1;
      convert(1, 20, 1'b0);
      convert(1, 3, 1'b1);
      idle_chk(60);
      summarize();
   end
endmodule
